/* hw/data_memory_pkg.sv */
// types for the sectored data memory
package data_memory_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_READ,
        OP_WRITE,
        OP_BIT_SET,
        OP_BIT_CLR,
        OP_INC,
        OP_DEC
    } mem_op_t;
endpackage

/* hw/data_memory_regs.svh */
// address map and field constants for the sectored data memory
`ifndef DATA_MEMORY_REGS_SVH
`define DATA_MEMORY_REGS_SVH
`define SFR_TOP          8'h7f
`define SECTOR_COUNT     4
`define SECTOR_BITS      2
`define ADDR_BITS        10
`define ADDR_IND0        8'h00
`define ADDR_PTR0        8'h01
`define ADDR_IND1        8'h02
`define ADDR_PTR_A_LOW   8'h03
`define ADDR_PTR_A_SEC   8'h04
`define ADDR_IND2        8'h05
`define ADDR_ACC         8'h06
`define ADDR_PTR_B_LOW   8'h07
`define ADDR_PTR_B_SEC   8'h08
`define ADDR_EEC         8'h40
`define EEC_SECTOR       2'h1
`define EEC_WMASK        8'h0f
`define PTR_RESET        8'h00
`endif

/* hw/sectored_data_memory.sv */
// sectored data memory with direct and indirect address generation
//
// Function
// - each sector is 8-bit RAM, low half 00h-7fh holds special registers in sectors 0 and 1 only
// - general RAM at 80h-ffh in sectors 0 to 3, 512 bytes total
// - sector 1 holds only the eeprom control register at 40h
// - no bank register; indirect sector from high pointer, offset from low pointer
// - extended instructions carry 10-bit address: sector bits plus low byte
// - full extended address reaches ram in every sector but not the sector 1 eec; short address reaches sector 0
// - reads of unused special addresses return zero
// - access to an indirect port goes to the address its pointers hold
// - port zero reaches sector 0 only; ports one and two reach any sector
// - indirect ports have no storage: a pointer aimed at one reads zero, write ignored
// - five pointers are real registers, readable, writable and modifiable
// - general RAM supports byte read, byte write, bit set and bit clear
// - protected bits of read-only registers ignore writes
// - accumulator takes results; memory-to-memory moves go through it
`timescale 1ns/100ps
`include "data_memory_regs.svh"
module sectored_data_memory (
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clk_en,
    input  wire data_memory_pkg::mem_op_t    mem_op,
    input  wire logic                        extended,
    input  wire logic [9:0]                  mem_addr,
    input  wire logic [7:0]                  wr_data,
    input  wire logic [2:0]                  bit_sel,
    input  wire logic                        to_acc,
    input  wire logic [7:0]                  alu_result,
    input  wire logic                        alu_load,
    output logic      [7:0]                  rd_data,
    output logic      [7:0]                  acc,
    output logic      [7:0]                  eeprom_control_register
);
    logic [7:0] gp_ram [0:`SECTOR_COUNT*128-1];
    logic [7:0] sector0_pointer_q;
    logic [7:0] pointer_a_low_q;
    logic [7:0] pointer_a_sector_q;
    logic [7:0] pointer_b_low_q;
    logic [7:0] pointer_b_sector_q;
    logic [7:0] eec_q;
    logic [7:0] acc_q;
    logic [7:0] rd_q;

    wire [1:0] dir_sector = extended ? mem_addr[9:8] : 2'h0;
    wire [7:0] dir_low    = mem_addr[7:0];
    wire       hit_ind0   = (dir_sector == 2'h0) && (dir_low == `ADDR_IND0);
    wire       hit_ind1   = (dir_sector == 2'h0) && (dir_low == `ADDR_IND1);
    wire       hit_ind2   = (dir_sector == 2'h0) && (dir_low == `ADDR_IND2);
    wire [1:0] eff_sector = hit_ind0 ? 2'h0 :
                            hit_ind1 ? pointer_a_sector_q[`SECTOR_BITS-1:0] :
                            hit_ind2 ? pointer_b_sector_q[`SECTOR_BITS-1:0] : dir_sector;
    wire [7:0] eff_low    = hit_ind0 ? sector0_pointer_q :
                            hit_ind1 ? pointer_a_low_q :
                            hit_ind2 ? pointer_b_low_q : dir_low;
    // low half special registers, high half ram
    wire       is_gp      = eff_low > `SFR_TOP;
    wire [8:0] gp_index   = {eff_sector, eff_low[6:0]};
    // a pointer aimed at a port itself lands on nothing
    wire       eff_port   = (eff_sector == 2'h0) && ((eff_low == `ADDR_IND0)
                            || (eff_low == `ADDR_IND1) || (eff_low == `ADDR_IND2));

    function automatic logic sfr_match(input logic [1:0] s, input logic [7:0] l,
                                       input logic [1:0] ts, input logic [7:0] tl);
        sfr_match = (s == ts) && (l == tl);
    endfunction

    wire sel_p0  = sfr_match(eff_sector, eff_low, 2'h0, `ADDR_PTR0);
    wire sel_pal = sfr_match(eff_sector, eff_low, 2'h0, `ADDR_PTR_A_LOW);
    wire sel_pas = sfr_match(eff_sector, eff_low, 2'h0, `ADDR_PTR_A_SEC);
    wire sel_pbl = sfr_match(eff_sector, eff_low, 2'h0, `ADDR_PTR_B_LOW);
    wire sel_pbs = sfr_match(eff_sector, eff_low, 2'h0, `ADDR_PTR_B_SEC);
    wire sel_acc = sfr_match(eff_sector, eff_low, 2'h0, `ADDR_ACC);
    // only sfr in sector 1, reached through a pointer pair only
    wire sel_eec = (hit_ind1 || hit_ind2)
                   && sfr_match(eff_sector, eff_low, `EEC_SECTOR, `ADDR_EEC);

    // unused and port addresses read zero
    wire [7:0] cur_val = eff_port ? 8'h00 :
                         is_gp    ? gp_ram[gp_index] :
                         sel_p0   ? sector0_pointer_q :
                         sel_pal  ? pointer_a_low_q :
                         sel_pas  ? pointer_a_sector_q :
                         sel_pbl  ? pointer_b_low_q :
                         sel_pbs  ? pointer_b_sector_q :
                         sel_acc  ? acc_q :
                         sel_eec  ? eec_q : 8'h00;

    wire [7:0] bit_mask = 8'h01 << bit_sel;
    wire [7:0] new_val  = (mem_op == data_memory_pkg::OP_BIT_SET) ? (cur_val | bit_mask) :
                          (mem_op == data_memory_pkg::OP_BIT_CLR) ? (cur_val & ~bit_mask) :
                          (mem_op == data_memory_pkg::OP_INC)     ? cur_val + 8'h01 :
                          (mem_op == data_memory_pkg::OP_DEC)     ? cur_val - 8'h01 :
                          wr_data;
    wire do_wr  = clk_en && !eff_port && (mem_op != data_memory_pkg::OP_NONE)
                  && (mem_op != data_memory_pkg::OP_READ);
    // results land in accumulator when steered there
    wire acc_dest = to_acc && (mem_op != data_memory_pkg::OP_WRITE)
                    && (mem_op != data_memory_pkg::OP_READ);

    // general ram, no reset: contents are volatile
    always_ff @(posedge core_clk) begin
        if (do_wr && is_gp && !acc_dest) begin
            gp_ram[gp_index] <= new_val;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sector0_pointer_q  <= `PTR_RESET;
            pointer_a_low_q    <= `PTR_RESET;
            pointer_a_sector_q <= `PTR_RESET;
            pointer_b_low_q    <= `PTR_RESET;
            pointer_b_sector_q <= `PTR_RESET;
        end else if (do_wr && !acc_dest) begin
            if (sel_p0)  sector0_pointer_q  <= new_val;
            if (sel_pal) pointer_a_low_q    <= new_val;
            if (sel_pas) pointer_a_sector_q <= new_val;
            if (sel_pbl) pointer_b_low_q    <= new_val;
            if (sel_pbs) pointer_b_sector_q <= new_val;
        end
    end

    // upper eec bits are status and stay put
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            eec_q <= 8'h00;
        end else if (do_wr && sel_eec && !acc_dest) begin
            eec_q <= (eec_q & ~`EEC_WMASK) | (new_val & `EEC_WMASK);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc_q <= 8'h00;
        end else if (clk_en && alu_load) begin
            acc_q <= alu_result;
        end else if (clk_en && mem_op == data_memory_pkg::OP_READ && to_acc) begin
            acc_q <= cur_val;
        end else if (do_wr && (acc_dest || sel_acc)) begin
            acc_q <= new_val;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_q <= 8'h00;
        end else if (clk_en && mem_op == data_memory_pkg::OP_READ) begin
            rd_q <= cur_val;
        end
    end

    assign rd_data                 = rd_q;
    assign acc                     = acc_q;
    assign eeprom_control_register = eec_q;

    // port reads come back zero
    a_port_reads_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && mem_op == data_memory_pkg::OP_READ && eff_port |=> rd_q == 8'h00)
        else $error("indirect port read not zero");
    a_short_sector_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        !extended && !hit_ind1 && !hit_ind2 |-> eff_sector == 2'h0)
        else $error("short address left sector 0");
    a_port0_sector_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        hit_ind0 |-> eff_sector == 2'h0 && eff_low == sector0_pointer_q)
        else $error("port zero left sector 0");
    a_port1_redirect: assert property (@(posedge core_clk) disable iff (sys_rst)
        hit_ind1 |-> eff_sector == pointer_a_sector_q[1:0] && eff_low == pointer_a_low_q)
        else $error("port one redirect wrong");
    a_port2_redirect: assert property (@(posedge core_clk) disable iff (sys_rst)
        hit_ind2 |-> eff_sector == pointer_b_sector_q[1:0] && eff_low == pointer_b_low_q)
        else $error("port two redirect wrong");
    a_unused_reads_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && mem_op == data_memory_pkg::OP_READ && !is_gp && !sel_p0 && !sel_pal
        && !sel_pas && !sel_pbl && !sel_pbs && !sel_acc && !sel_eec |=> rd_q == 8'h00)
        else $error("unused address read not zero");
    a_eec_protected: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> (eec_q & ~`EEC_WMASK) == ($past(eec_q) & ~`EEC_WMASK))
        else $error("protected eec bits changed");
    a_pointer_inc: assert property (@(posedge core_clk) disable iff (sys_rst)
        do_wr && sel_p0 && !acc_dest && mem_op == data_memory_pkg::OP_INC
        |=> sector0_pointer_q == $past(sector0_pointer_q) + 8'h01)
        else $error("pointer increment lost");
    a_alu_to_acc: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && alu_load |=> acc_q == $past(alu_result))
        else $error("alu result not in accumulator");
    a_freeze: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en |=> $stable(rd_q) && $stable(acc_q))
        else $error("state moved while frozen");
    a_eec_indirect_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        !hit_ind1 && !hit_ind2 |=> $stable(eec_q))
        else $error("eec changed without a pointer pair");

    // write then read back of one ram byte
    sequence s_gp_write;
        clk_en && mem_op == data_memory_pkg::OP_WRITE && is_gp;
    endsequence
    sequence s_gp_readback;
        clk_en && mem_op == data_memory_pkg::OP_READ && is_gp && gp_index == $past(gp_index);
    endsequence
    a_gp_write_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_gp_write ##1 s_gp_readback |=> rd_q == $past(wr_data, 2))
        else $error("ram byte not read back");
    a_ptr_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && mem_op == data_memory_pkg::OP_WRITE && sel_pal
        |=> pointer_a_low_q == $past(wr_data))
        else $error("pointer write lost");
    a_acc_takes_inc: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !alu_load && to_acc && mem_op == data_memory_pkg::OP_INC && !eff_port
        |=> acc_q == $past(cur_val) + 8'h01)
        else $error("increment result missed accumulator");
    a_rd_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(clk_en && mem_op == data_memory_pkg::OP_READ) |=> $stable(rd_q))
        else $error("read data moved without a read");
    a_freeze_regs: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en |=> $stable(sector0_pointer_q) && $stable(pointer_a_low_q) && $stable(eec_q))
        else $error("registers moved while frozen");
    a_ext_sector: assert property (@(posedge core_clk) disable iff (sys_rst)
        extended && is_gp && !hit_ind0 && !hit_ind1 && !hit_ind2
        |-> gp_index[8:7] == mem_addr[9:8])
        else $error("extended address missed its sector");
endmodule // sectored_data_memory

/* sim/cpu_datapath_model.sv */
// cpu datapath model: one instruction per cycle into the data memory
`timescale 1ns/100ps
module cpu_datapath_model (
    input  wire logic                core_clk,
    output data_memory_pkg::mem_op_t mem_op,
    output logic                     extended,
    output logic [9:0]               mem_addr,
    output logic [7:0]               wr_data,
    output logic [2:0]               bit_sel,
    output logic                     to_acc
);
    initial begin
        {extended, mem_addr, wr_data, bit_sel, to_acc} = '0;
        mem_op = data_memory_pkg::OP_NONE;
    end
    // held past the taking edge until the next call, so the caller must follow inc/dec at once
    task automatic issue(input data_memory_pkg::mem_op_t o, input logic e,
                         input logic [9:0] a, input logic [7:0] d, input logic [3:0] bt);
        mem_op = o;
        {extended, mem_addr, wr_data} = {e, a, d};
        {to_acc, bit_sel} = bt;
        @(posedge core_clk);
        #1;
    endtask
endmodule // cpu_datapath_model

/* sim/testbench.sv */
// self-checking bench for the sectored data memory
`timescale 1ns/100ps
module testbench;
    logic                     core_clk, sys_rst, clk_en, alu_load, extended, to_acc;
    logic [7:0]               alu_result, rd_data, acc, eeprom_control_register, wr_data;
    data_memory_pkg::mem_op_t mem_op;
    logic [9:0]               mem_addr;
    logic [2:0]               bit_sel;
    int                       n_fail = 0;
    int                       total_checks = 0;

    cpu_datapath_model u_cpu_datapath_model (.core_clk, .mem_op, .extended, .mem_addr,
        .wr_data, .bit_sel, .to_acc);
    sectored_data_memory u_sectored_data_memory (.core_clk, .sys_rst, .clk_en, .mem_op,
        .extended, .mem_addr, .wr_data, .bit_sel, .to_acc, .alu_result, .alu_load,
        .rd_data, .acc, .eeprom_control_register);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, x, g);
        end
    endtask
    task automatic op(input data_memory_pkg::mem_op_t o, input logic [9:0] a,
                      input logic [7:0] d, input logic [3:0] bt);
        u_cpu_datapath_model.issue(o, 1'b1, a, d, bt);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        op(data_memory_pkg::OP_WRITE, a, d, 4'h0);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] x);
        op(data_memory_pkg::OP_READ, a, 8'h00, 4'h0);
        chk("rd_data", x, rd_data);
    endtask

    task automatic t_ram;
        for (int s = 0; s < 4; s++) begin
            wr({s[1:0], 8'h80}, 8'(s));
            wr({s[1:0], 8'hff}, ~8'(s));
        end
        for (int s = 0; s < 4; s++) begin
            rd({s[1:0], 8'h80}, 8'(s));
            rd({s[1:0], 8'hff}, ~8'(s));
        end
        wr(10'h3c0, 8'h11);
        u_cpu_datapath_model.issue(data_memory_pkg::OP_WRITE, 1'b0, 10'h3c0, 8'h77, 4'h0);
        rd(10'h3c0, 8'h11);
        rd(10'h0c0, 8'h77);
        wr(10'h1a5, 8'h0f);
        op(data_memory_pkg::OP_BIT_SET, 10'h1a5, 8'h00, 4'h7);
        op(data_memory_pkg::OP_BIT_CLR, 10'h1a5, 8'h00, 4'h0);
        rd(10'h1a5, 8'h8e);
    endtask
    task automatic t_ind;
        wr(10'h001, 8'h85);
        wr(10'h000, 8'h55);
        rd(10'h085, 8'h55);
        wr(10'h003, 8'h90);
        wr(10'h004, 8'h05);
        wr(10'h002, 8'h66);
        rd(10'h190, 8'h66);
        wr(10'h007, 8'hb0);
        wr(10'h008, 8'h03);
        wr(10'h005, 8'h99);
        rd(10'h3b0, 8'h99);
        rd(10'h005, 8'h99);
        wr(10'h001, 8'h00);
        rd(10'h000, 8'h00);
        wr(10'h001, 8'hfe);
        op(data_memory_pkg::OP_INC, 10'h001, 8'h00, 4'h0);
        op(data_memory_pkg::OP_INC, 10'h001, 8'h00, 4'h0);
        op(data_memory_pkg::OP_DEC, 10'h001, 8'h00, 4'h0);
        rd(10'h001, 8'hff);
    endtask
    task automatic t_sfr;
        wr(10'h003, 8'h40);
        wr(10'h004, 8'h01);
        wr(10'h002, 8'hff);
        rd(10'h002, 8'h0f);
        chk("eec", 8'h0f, eeprom_control_register);
        wr(10'h140, 8'h00);
        chk("eec", 8'h0f, eeprom_control_register);
        rd(10'h140, 8'h00);
        wr(10'h020, 8'hff);
        rd(10'h020, 8'h00);
        rd(10'h250, 8'h00);
    endtask
    task automatic t_acc;
        alu_result = 8'h3c;
        alu_load = 1'b1;
        op(data_memory_pkg::OP_NONE, 10'h000, 8'h00, 4'h0);
        alu_load = 1'b0;
        chk("acc", 8'h3c, acc);
        rd(10'h006, 8'h3c);
        op(data_memory_pkg::OP_READ, 10'h085, 8'h00, 4'h8);
        chk("acc", 8'h55, acc);
        wr(10'h0c1, acc);
        rd(10'h0c1, 8'h55);
        // frozen cycle must not commit the write
        clk_en = 1'b0;
        wr(10'h0c1, 8'hee);
        clk_en = 1'b1;
        rd(10'h0c1, 8'h55);
        op(data_memory_pkg::OP_INC, 10'h0c1, 8'h00, 4'h8);
        chk("acc", 8'h56, acc);
        op(data_memory_pkg::OP_BIT_SET, 10'h0c1, 8'h00, 4'hf);
        chk("acc", 8'hd5, acc);
        rd(10'h0c1, 8'h55);
    endtask
    task automatic t_rst;
        sys_rst = 1'b1;
        op(data_memory_pkg::OP_NONE, 10'h000, 8'h00, 4'h0);
        op(data_memory_pkg::OP_NONE, 10'h000, 8'h00, 4'h0);
        sys_rst = 1'b0;
        chk("acc", 8'h00, acc);
        chk("eec", 8'h00, eeprom_control_register);
        rd(10'h004, 8'h00);
        rd(10'h007, 8'h00);
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        {sys_rst, clk_en, alu_load, alu_result} = {1'b1, 1'b1, 1'b0, 8'h00};
        repeat (10) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        chk("acc", 8'h00, acc);
        rd(10'h001, 8'h00);
        t_ram;
        t_ind;
        t_sfr;
        t_acc;
        t_rst;
        op(data_memory_pkg::OP_NONE, 10'h000, 8'h00, 4'h0);
        summarize;
    end

    // about 80 cycles of traffic; generous margin before giving up
    initial begin
        #(2000 * 100);
        n_fail++;
        summarize;
    end
endmodule // testbench
